// ==== src/tpc_pkg.sv ====
package tpc_pkg;
	// ------------------------------------------------------------
	// bus and register map
	// ------------------------------------------------------------
	localparam int unsigned APB_AW = 12;
	localparam logic [11:0] OFS_CLOCK_SELECT  = 12'h000;
	localparam logic [11:0] OFS_MODE_CONTROL  = 12'h004;
	localparam logic [11:0] OFS_OUTPUT_CTRL   = 12'h008;
	localparam logic [11:0] OFS_EDGE_MODE     = 12'h00C;
	localparam logic [11:0] OFS_SAMPLE_SELECT = 12'h010;
	localparam logic [11:0] OFS_PROC_CLOCK    = 12'h014;
	localparam logic [11:0] OFS_COMPARE       = 12'h018;
	localparam logic [11:0] OFS_CAPTURE       = 12'h01C;
	localparam logic [11:0] OFS_COUNT         = 12'h020;
	localparam logic [11:0] OFS_PORT_DIR      = 12'h024;
	localparam logic [11:0] OFS_PORT_LATCH    = 12'h028;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int unsigned CS_LSB    = 4;
	localparam int unsigned MODE_LSB  = 1;
	localparam int unsigned OVF_BIT   = 0;
	localparam int unsigned TOC_OE    = 0;
	localparam int unsigned TOC_LEVEL = 1;
	localparam int unsigned TOC_FRST  = 2;
	localparam int unsigned TOC_FSET  = 3;
	localparam int unsigned EDGE0_LSB = 2;
	localparam int unsigned PIN_BIT   = 0;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  REG8_RST = 8'h00;
	localparam logic [7:0]  DIR_RST  = 8'hFF;
	localparam logic [15:0] CMP_RST  = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_ONE  = 16'h0001;
	localparam logic [15:0] CNT_MAX  = 16'hFFFF;
	// ------------------------------------------------------------
	// encodings
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		TPC_MODE_STOP         = 3'b000,
		TPC_MODE_PWM          = 3'b001,
		TPC_MODE_FREE         = 3'b010,
		TPC_MODE_FREE_EDGE    = 3'b011,
		TPC_MODE_RESTART      = 3'b100,
		TPC_MODE_RESTART_EDGE = 3'b101,
		TPC_MODE_INTERVAL     = 3'b110,
		TPC_MODE_INTERVAL_EDGE = 3'b111
	} tpc_mode_t;
	localparam logic [2:0] CS_PIN  = 3'b000;
	localparam logic [2:0] CS_DIV2 = 3'b010;
	localparam logic [2:0] CS_DIV4 = 3'b011;
	localparam logic [2:0] CS_DIV8 = 3'b100;
	localparam logic [1:0] EDGE_FALL = 2'b00;
	localparam logic [1:0] EDGE_RISE = 2'b01;
	localparam logic [1:0] EDGE_BOTH = 2'b11;
	localparam logic [1:0] SCS_CPU    = 2'b00;
	localparam logic [1:0] SCS_DIV128 = 2'b10;
	localparam logic [1:0] SCS_DIV64  = 2'b11;
	// ------------------------------------------------------------
	// prescaler and pwm
	// ------------------------------------------------------------
	localparam int unsigned DIV_W      = 7;
	localparam logic [6:0]  MASK_DIV2   = 7'h01;
	localparam logic [6:0]  MASK_DIV4   = 7'h03;
	localparam logic [6:0]  MASK_DIV8   = 7'h07;
	localparam logic [6:0]  MASK_DIV64  = 7'h3F;
	localparam logic [6:0]  MASK_DIV128 = 7'h7F;
	localparam int unsigned PWM_BASE_W = 8;
	localparam int unsigned PWM_SUB_W  = 6;
	localparam int unsigned PWM_FRAC_LSB = 2;
	localparam int unsigned NUM_INPUTS = 4;
endpackage : tpc_pkg

// ==== src/tpc_tick_if.sv ====
`timescale 1ns/10ps
interface tpc_tick_if;
	logic count_tick;
	logic sample_tick;
	modport src (output count_tick, output sample_tick);
	modport dst (input count_tick, input sample_tick);
endinterface : tpc_tick_if

// ==== src/tpc_prescaler.sv ====
`timescale 1ns/10ps
module tpc_prescaler
	import tpc_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic       nrst_i,
	input  wire logic [2:0] clk_sel_i,
	input  wire logic [1:0] scs_i,
	input  wire logic [2:0] pcc_i,
	input  wire logic       halt_i,
	tpc_tick_if.src         ticks
);
	typedef struct packed {
		logic [DIV_W-1:0] div;
		logic             count_tick;
		logic             sample_tick;
	} tpc_pre_t;

	tpc_pre_t cur_reg;
	tpc_pre_t cur_next;
	logic [7:0] cpu_span;
	logic [DIV_W-1:0] cmask;
	logic [DIV_W-1:0] smask;

	always_comb begin
		cur_next = cur_reg;
		cur_next.div = DIV_W'(cur_reg.div + 7'h01);
		cpu_span = 8'h02 << pcc_i;
		cmask = MASK_DIV8;
		if (clk_sel_i == CS_DIV2) begin // see RL11
			cmask = MASK_DIV2;
		end else if (clk_sel_i == CS_DIV4) begin
			cmask = MASK_DIV4;
		end
		smask = DIV_W'(cpu_span - 8'h01);
		if (scs_i == SCS_DIV128) begin // see RL7
			smask = MASK_DIV128;
		end else if (scs_i == SCS_DIV64) begin
			smask = MASK_DIV64;
		end
		cur_next.count_tick = (cur_reg.div & cmask) == cmask;
		// the processor-derived clock stops in halt, the fixed ones run on
		cur_next.sample_tick = ((cur_reg.div & smask) == smask)
			&& !(halt_i && scs_i != SCS_DIV128 && scs_i != SCS_DIV64); // see RL8
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cur_reg <= '0;
		end else begin
			cur_reg <= cur_next;
		end
	end

	assign ticks.count_tick = cur_reg.count_tick;
	assign ticks.sample_tick = cur_reg.sample_tick;

	a_halt_sample: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RL8
		(halt_i && scs_i != SCS_DIV128 && scs_i != SCS_DIV64) |=> !cur_reg.sample_tick)
		else $error("sampling clock ran during halt");
endmodule : tpc_prescaler

// ==== src/tpc_edge_filter.sv ====
`timescale 1ns/10ps
module tpc_edge_filter
	import tpc_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic       nrst_i,
	input  wire logic       pin_i,
	input  wire logic       sample_i,
	input  wire logic [1:0] edge_sel_i,
	output logic            edge_o
);
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic hist;
		logic level;
		logic edge_hit;
	} tpc_filt_t;

	tpc_filt_t cur_reg;
	tpc_filt_t cur_next;
	logic      want_rise;
	logic      want_fall;

	always_comb begin
		cur_next = cur_reg;
		cur_next.sync1 = pin_i;
		cur_next.sync2 = cur_reg.sync1;
		cur_next.edge_hit = 1'b0;
		want_rise = (edge_sel_i == EDGE_RISE) || (edge_sel_i == EDGE_BOTH); // see RL19
		want_fall = (edge_sel_i == EDGE_FALL) || (edge_sel_i == EDGE_BOTH);
		if (sample_i) begin
			cur_next.hist = cur_reg.sync2;
			// a new level counts only once two samples in a row agree
			if (cur_reg.sync2 == cur_reg.hist && cur_reg.sync2 != cur_reg.level) begin // see RL20
				cur_next.level = cur_reg.sync2;
				cur_next.edge_hit = (want_rise && cur_reg.sync2) || (want_fall && !cur_reg.sync2);
			end
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cur_reg <= '0;
		end else begin
			cur_reg <= cur_next;
		end
	end

	assign edge_o = cur_reg.edge_hit;

	a_edge_confirm: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RL20
		cur_reg.edge_hit |-> (cur_reg.hist == cur_reg.level) && ($past(cur_reg.hist) == cur_reg.level))
		else $error("edge accepted without two agreeing samples");
endmodule : tpc_edge_filter

// ==== src/tpc_timer.sv ====
// How it works
// RL1: output control register drives level flop, pwm level, toggle, output; resets zero.
// RL2: force-set and force-reset bits always read back as zero.
// RL3: software stops the timer before rewriting output control.
// RL4: software clears pin direction bit and latch to route timer output.
// RL5: edge register picks edges for inputs zero to two; input three falls.
// RL6: software changes capture edge only while the timer is stopped.
// RL7: sampling select register, reset zero, picks the capture input sample clock.
// RL8: processor-derived sample clock halts in halt mode; divide by 64/128 runs.
// RL9: interval mode clears count on compare match, keeps counting, raises interrupt.
// RL10: interval lasts compare value plus one count clocks.
// RL11: clock select picks pin edges, or main clock divided by 2, 4, 8.
// RL12: pwm mode drives pulses on the output pin set by compare value.
// RL13: software writes pwm width in upper 14 compare bits, low bits zero.
// RL14: in pwm, output control bit 1 sets level, bit 0 enables output.
// RL15: pwm has 14-bit resolution from 2^8 basic and 2^6 sub-cycles.
// RL16: software selects pwm mode before writing the compare register.
// RL17: software never uses pwm with pin edges as count clock.
// RL18: free-running mode copies count to capture on each valid edge, interrupts.
// RL19: capture edge is rising, falling or both via edge register bits 2, 3.
// RL20: capture input is sampled; edge accepted after two equal new samples.
// RL21: restart mode captures count on valid edge, then clears and recounts.
// RL22: stop mode code holds count at zero.
// RL23: software writes only nonzero compare values.
// RL24: edge during capture read keeps old capture yet still interrupts.
// RL25: match and capture interrupts are one-clock pulses per event.
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/10ps
module tpc_timer
	import tpc_pkg::*;
(
	input  wire logic              clock_i,
	input  wire logic              nrst_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [APB_AW-1:0] paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic [31:0]            prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	input  wire logic              event_pin_i,
	input  wire logic [2:0]        ext_int_pin_i,
	input  wire logic              cpu_halt_i,
	output logic                   timer_pin_o,
	output logic                   timer_pin_oe_n_o,
	output logic                   match_irq_o,
	output logic                   capture_irq_o,
	output logic [2:0]             ext_irq_o
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0]  clk_sel;
		tpc_mode_t   mode;
		logic        ovf;
		logic [1:0]  toc;
		logic [7:0]  edge_sel;
		logic [1:0]  sampling_clock_select;
		logic [2:0]  processor_clock_control;
		logic [15:0] cmp;
		logic [15:0] cap;
		logic [15:0] count;
		logic [7:0]  dir;
		logic [7:0]  latch;
		logic        lvl;
		logic        tout;
		logic        match_irq;
		logic        cap_irq;
		logic [2:0]  ext_irq;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        pin_o;
		logic        pin_oe_n;
	} tpc_core_t;

	localparam tpc_core_t CORE_RST = '{
		mode:     TPC_MODE_STOP,
		edge_sel: REG8_RST,
		cmp:      CMP_RST,
		dir:      DIR_RST,
		latch:    REG8_RST,
		pin_oe_n: 1'b1,
		default:  '0
	};

	tpc_core_t cur_reg;
	tpc_core_t cur_next;

	// ------------------------------------------------------------
	// clocks and edge filters
	// ------------------------------------------------------------
	tpc_tick_if ticks ();

	tpc_prescaler u_prescaler (
		.clock_i   (clock_i),
		.nrst_i    (nrst_i),
		.clk_sel_i (cur_reg.clk_sel),
		.scs_i     (cur_reg.sampling_clock_select),
		.pcc_i     (cur_reg.processor_clock_control),
		.halt_i    (cpu_halt_i),
		.ticks     (ticks.src)
	);

	logic [NUM_INPUTS-1:0]       pins;
	logic [NUM_INPUTS-1:0]       edges;
	logic [NUM_INPUTS-1:0][1:0]  esel;

	assign pins = {ext_int_pin_i, event_pin_i};

	genvar g;
	generate
		for (g = 0; g < NUM_INPUTS; g++) begin : g_filt
			if (g == NUM_INPUTS - 1) begin : g_fixed
				assign esel[g] = EDGE_FALL; // see RL5
			end else begin : g_prog
				assign esel[g] = cur_reg.edge_sel[EDGE0_LSB + 2 * g +: 2]; // see RL5
			end
			tpc_edge_filter u_filt (
				.clock_i    (clock_i),
				.nrst_i     (nrst_i),
				.pin_i      (pins[g]),
				.sample_i   ((g == 0) ? ticks.sample_tick : 1'b1),
				.edge_sel_i (esel[g]),
				.edge_o     (edges[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// pwm waveform
	// ------------------------------------------------------------
	logic [PWM_SUB_W-1:0] sub_rev;

	generate
		for (g = 0; g < PWM_SUB_W; g++) begin : g_rev
			// bit-reversed sub-cycle index spreads the extra clocks evenly
			assign sub_rev[g] = cur_reg.count[PWM_BASE_W + PWM_SUB_W - 1 - g]; // see RL15
		end
	endgenerate

	logic             pwm_add;
	logic [PWM_BASE_W:0] pwm_width;
	logic             pwm_active;

	assign pwm_add = sub_rev < cur_reg.cmp[PWM_FRAC_LSB +: PWM_SUB_W]; // see RL15
	assign pwm_width = (PWM_BASE_W + 1)'({1'b0, cur_reg.cmp[15 -: PWM_BASE_W]} + {{PWM_BASE_W{1'b0}}, pwm_add});
	assign pwm_active = {1'b0, cur_reg.count[PWM_BASE_W-1:0]} < pwm_width;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	logic        setup;
	logic        wr;
	logic        cap_read;
	logic        tick;
	logic        running;
	logic        is_pwm;
	logic        is_interval;
	logic        is_restart;
	logic        hit;
	logic        ovf_set;
	logic [31:0] rd;
	logic        mapped;

	always_comb begin
		cur_next = cur_reg;
		cur_next.match_irq = 1'b0;
		cur_next.cap_irq = 1'b0;
		setup = psel_i && !penable_i;
		wr = psel_i && penable_i && pwrite_i && cur_reg.pready;
		cap_read = psel_i && !pwrite_i && paddr_i == OFS_CAPTURE;
		tick = (cur_reg.clk_sel == CS_PIN) ? edges[0] : ticks.count_tick; // see RL11
		running = cur_reg.mode != TPC_MODE_STOP;
		is_pwm = cur_reg.mode == TPC_MODE_PWM;
		is_interval = cur_reg.mode inside {TPC_MODE_INTERVAL, TPC_MODE_INTERVAL_EDGE};
		is_restart = cur_reg.mode inside {TPC_MODE_RESTART, TPC_MODE_RESTART_EDGE};
		hit = running && tick && cur_reg.count == cur_reg.cmp;
		ovf_set = running && tick && cur_reg.count == CNT_MAX;
		// counter
		if (!running) begin
			cur_next.count = CNT_ZERO; // see RL22
		end else if (tick) begin
			if (hit && is_interval) begin
				cur_next.count = CNT_ZERO; // see RL9 RL10
			end else begin
				cur_next.count = 16'(cur_reg.count + CNT_ONE);
			end
		end
		cur_next.match_irq = hit; // see RL9 RL25
		// capture
		if (running && !is_pwm && edges[0]) begin
			if (!cap_read) begin
				cur_next.cap = cur_reg.count; // see RL18 RL21 RL24
			end
			if (is_restart) begin
				cur_next.count = CNT_ZERO; // see RL21
			end
		end
		cur_next.cap_irq = edges[0]; // see RL18 RL24 RL25
		cur_next.ext_irq = edges[NUM_INPUTS-1:1]; // see RL5
		// output level flop toggles on match, and on edges in the edge modes
		if (running && !is_pwm && cur_reg.toc[TOC_OE] && cur_reg.toc[TOC_LEVEL]) begin // see RL1
			if (hit || (cur_reg.mode[0] && edges[0])) begin
				cur_next.lvl = !cur_reg.lvl;
			end
		end
		// register writes
		if (wr) begin
			unique case (paddr_i)
				OFS_CLOCK_SELECT: cur_next.clk_sel = pwdata_i[CS_LSB +: 3];
				OFS_MODE_CONTROL: begin
					cur_next.mode = tpc_mode_t'(pwdata_i[MODE_LSB +: 3]);
					cur_next.ovf = pwdata_i[OVF_BIT];
				end
				OFS_OUTPUT_CTRL: begin
					cur_next.toc = pwdata_i[TOC_LEVEL:TOC_OE]; // see RL1 RL14
					if (pwdata_i[TOC_FSET]) begin
						cur_next.lvl = 1'b1;
					end else if (pwdata_i[TOC_FRST]) begin
						cur_next.lvl = 1'b0;
					end
				end
				OFS_EDGE_MODE:     cur_next.edge_sel = {pwdata_i[7:EDGE0_LSB], 2'b00}; // see RL5
				OFS_SAMPLE_SELECT: cur_next.sampling_clock_select = pwdata_i[1:0]; // see RL7
				OFS_PROC_CLOCK:    cur_next.processor_clock_control = pwdata_i[2:0];
				OFS_COMPARE:       cur_next.cmp = pwdata_i[15:0];
				OFS_PORT_DIR:      cur_next.dir = pwdata_i[7:0];
				OFS_PORT_LATCH:    cur_next.latch = pwdata_i[7:0];
				default: begin
				end
			endcase
		end
		// hardware set wins over a software clear
		if (ovf_set) begin
			cur_next.ovf = 1'b1;
		end
		// timer output
		if (is_pwm) begin
			cur_next.tout = cur_reg.toc[TOC_OE] && (pwm_active ^ cur_reg.toc[TOC_LEVEL]); // see RL12 RL14
		end else begin
			cur_next.tout = cur_reg.toc[TOC_OE] && cur_reg.lvl; // see RL1
		end
		cur_next.pin_o = cur_reg.latch[PIN_BIT] | cur_reg.tout;
		cur_next.pin_oe_n = cur_reg.dir[PIN_BIT];
		// apb read mux, taken in the setup cycle
		mapped = 1'b1;
		unique case (paddr_i)
			OFS_CLOCK_SELECT:  rd = 32'(cur_reg.clk_sel) << CS_LSB;
			OFS_MODE_CONTROL:  rd = 32'({cur_reg.mode, cur_reg.ovf});
			OFS_OUTPUT_CTRL:   rd = 32'(cur_reg.toc); // see RL2
			OFS_EDGE_MODE:     rd = 32'(cur_reg.edge_sel);
			OFS_SAMPLE_SELECT: rd = 32'(cur_reg.sampling_clock_select);
			OFS_PROC_CLOCK:    rd = 32'(cur_reg.processor_clock_control);
			OFS_COMPARE:       rd = 32'(cur_reg.cmp);
			OFS_CAPTURE:       rd = 32'(cur_reg.cap);
			OFS_COUNT:         rd = 32'(cur_reg.count);
			OFS_PORT_DIR:      rd = 32'(cur_reg.dir);
			OFS_PORT_LATCH:    rd = 32'(cur_reg.latch);
			default: begin
				rd = 32'h0000_0000;
				mapped = 1'b0;
			end
		endcase
		cur_next.pready = setup;
		cur_next.pslverr = setup && !mapped;
		cur_next.prdata = (setup && !pwrite_i) ? rd : 32'h0000_0000;
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cur_reg <= CORE_RST;
		end else begin
			cur_reg <= cur_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign prdata_o = cur_reg.prdata;
	assign pready_o = cur_reg.pready;
	assign pslverr_o = cur_reg.pslverr;
	assign timer_pin_o = cur_reg.pin_o;
	assign timer_pin_oe_n_o = cur_reg.pin_oe_n;
	assign match_irq_o = cur_reg.match_irq;
	assign capture_irq_o = cur_reg.cap_irq;
	assign ext_irq_o = cur_reg.ext_irq;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_stop_holds_zero: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RL22
		(cur_reg.mode == TPC_MODE_STOP && $past(cur_reg.mode) == TPC_MODE_STOP) |-> cur_reg.count == CNT_ZERO)
		else $error("count not zero while stopped");

	a_interval_clear: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RL9
		(is_interval && tick && cur_reg.count == cur_reg.cmp && !(is_restart && edges[0]))
		|=> (cur_reg.count == CNT_ZERO) && match_irq_o)
		else $error("interval match did not clear and interrupt");

	a_force_bits_zero: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RL2
		(cur_reg.pready && psel_i && !pwrite_i && paddr_i == OFS_OUTPUT_CTRL)
		|-> !prdata_o[TOC_FSET] && !prdata_o[TOC_FRST])
		else $error("force bits read back nonzero");

	a_capture_hold: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RL24
		(edges[0] && cap_read && running && !is_pwm) |=> (cur_reg.cap == $past(cur_reg.cap)) && capture_irq_o)
		else $error("capture changed during read or no interrupt");

	a_restart_clear: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RL21
		(is_restart && edges[0] && !cap_read) |=> (cur_reg.count == CNT_ZERO) && (cur_reg.cap == $past(cur_reg.count)))
		else $error("restart edge did not capture and clear");

	a_free_capture: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RL18
		(cur_reg.mode == TPC_MODE_FREE && edges[0] && !cap_read) |=> (cur_reg.cap == $past(cur_reg.count)) ##1 !capture_irq_o)
		else $error("free-running capture wrong");

	a_irq_pulse: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RL25
		match_irq_o |=> !match_irq_o)
		else $error("match interrupt longer than one clock");

	a_pwm_disabled: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RL14
		(is_pwm && !cur_reg.toc[TOC_OE]) |=> !cur_reg.tout)
		else $error("pwm output active while disabled");

	a_overflow_set: assert property (@(posedge clock_i) disable iff (!nrst_i)
		ovf_set |=> cur_reg.ovf)
		else $error("overflow flag not set");
endmodule : tpc_timer

// ==== bench/tpc_pulse_model.sv ====
`timescale 1ns/10ps
module tpc_pulse_model (
	input  wire logic clock_i,
	input  wire logic out_pin_i,
	input  wire logic out_oe_n_i,
	input  wire logic clear_i,
	output logic      event_pin_o,
	output int        high_count_o
);
	// ------------------------------------------------------------
	// pulse source and output load
	// ------------------------------------------------------------
	initial event_pin_o = 1'b0;
	task automatic drive_level(input logic v);
		@(posedge clock_i);
		event_pin_o <= v;
	endtask : drive_level
	// load counts active cycles only while the pin is driven
	always_ff @(posedge clock_i) begin
		if (clear_i)
			high_count_o <= 0;
		else if (out_pin_i === 1'b1 && out_oe_n_i === 1'b0)
			high_count_o <= high_count_o + 1;
	end
endmodule : tpc_pulse_model

// ==== bench/tpc_timer_tb.sv ====
`timescale 1ns/10ps
module tpc_timer_tb;
	import tpc_pkg::*;
	logic        clock_i, nrst_i, psel, penable, pwrite, pready, pslverr, pin, clr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        tpin, toe_n, mirq, cirq, halt;
	logic [2:0]  ext, eirq;
	int          fails, checks, hc;
	bit          hit;
	// ------------------------------------------------------------
	// harness
	// ------------------------------------------------------------
	tpc_timer uut (.clock_i(clock_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .event_pin_i(pin), .ext_int_pin_i(ext),
		.cpu_halt_i(halt), .timer_pin_o(tpin), .timer_pin_oe_n_o(toe_n),
		.match_irq_o(mirq), .capture_irq_o(cirq), .ext_irq_o(eirq));
	tpc_pulse_model p (.clock_i(clock_i), .out_pin_i(tpin), .out_oe_n_i(toe_n),
		.clear_i(clr), .event_pin_o(pin), .high_count_o(hc));
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end
	task automatic finish_test;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test
	initial begin
		#100us;
		fails++;
		finish_test();
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			fails++;
		end
	endtask : check
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1'b1;
		do @(posedge clock_i); while (pready !== 1'b1);
		rd = prdata;
		hit = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_irq(ref logic sig, input int lim);
		hit = 0;
		for (int i = 0; i < lim && !hit; i++) begin
			@(negedge clock_i);
			hit = (sig === 1'b1);
		end
		if (hit) begin
			@(negedge clock_i);
			check("irq pulse width", 32'h0000_0000, {31'h0, sig});
		end
	endtask : wait_irq
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset_regs;
		apb(1'b0, OFS_OUTPUT_CTRL, 32'h0);
		check("output ctrl reset", 32'h0000_0000, rd);
		apb(1'b0, OFS_EDGE_MODE, 32'h0);
		check("edge mode reset", 32'h0000_0000, rd);
		apb(1'b0, OFS_SAMPLE_SELECT, 32'h0);
		check("sample select reset", 32'h0000_0000, rd);
		apb(1'b0, OFS_PORT_DIR, 32'h0);
		check("port dir reset", 32'h0000_00FF, rd);
		check("pin released", 32'h0000_0001, {31'h0, toe_n});
		apb(1'b0, 12'hFFC, 32'h0);
		check("unmapped error", 32'h0000_0001, {31'h0, hit});
		apb(1'b1, OFS_OUTPUT_CTRL, 32'h0000_000F);
		apb(1'b0, OFS_OUTPUT_CTRL, 32'h0);
		check("force bits read zero", 32'h0000_0003, rd);
	endtask : t_reset_regs
	task automatic t_interval;
		int n;
		apb(1'b1, OFS_CLOCK_SELECT, {25'h0, CS_DIV2, 4'h0});
		apb(1'b1, OFS_COMPARE, 32'h0000_0003);
		apb(1'b1, OFS_MODE_CONTROL, {28'h0, TPC_MODE_INTERVAL, 1'b0});
		wait_irq(mirq, 200);
		check("first match", 32'h0000_0001, {31'h0, hit});
		n = 1;
		while (mirq !== 1'b1 && n < 100) begin
			@(negedge clock_i);
			n++;
		end
		check("interval clocks", 32'h0000_0008, n);
		apb(1'b1, OFS_MODE_CONTROL, 32'h0);
		apb(1'b0, OFS_COUNT, 32'h0);
		check("stopped count", 32'h0000_0000, rd);
	endtask : t_interval
	task automatic t_pwm(input logic [31:0] toc, input int exp);
		apb(1'b1, OFS_MODE_CONTROL, 32'h0);
		apb(1'b1, OFS_OUTPUT_CTRL, toc);
		apb(1'b1, OFS_MODE_CONTROL, {28'h0, TPC_MODE_PWM, 1'b0});
		apb(1'b1, OFS_COMPARE, 32'h0000_4000);
		repeat (600) @(posedge clock_i);
		clr <= 1'b1;
		@(posedge clock_i);
		clr <= 1'b0;
		repeat (512) @(posedge clock_i);
		@(negedge clock_i);
		check("pwm active cycles", exp, hc);
	endtask : t_pwm
	task automatic t_capture;
		logic [31:0] c1;
		apb(1'b1, OFS_MODE_CONTROL, 32'h0);
		apb(1'b1, OFS_EDGE_MODE, 32'h0000_000C);
		apb(1'b1, OFS_SAMPLE_SELECT, {30'h0, SCS_DIV64});
		apb(1'b1, OFS_MODE_CONTROL, {28'h0, TPC_MODE_FREE, 1'b0});
		p.drive_level(1'b1);
		wait_irq(cirq, 1000);
		check("rise capture", 32'h0000_0001, {31'h0, hit});
		apb(1'b0, OFS_CAPTURE, 32'h0);
		c1 = rd;
		repeat (400) @(posedge clock_i);
		p.drive_level(1'b0);
		wait_irq(cirq, 1000);
		check("fall capture", 32'h0000_0001, {31'h0, hit});
		apb(1'b0, OFS_CAPTURE, 32'h0);
		check("capture advanced", 32'h0000_0001, {31'h0, (rd > c1 + 32'd130)});
		apb(1'b1, OFS_MODE_CONTROL, 32'h0);
		apb(1'b1, OFS_EDGE_MODE, {28'h0, EDGE_RISE, 2'b00});
		apb(1'b1, OFS_MODE_CONTROL, {28'h0, TPC_MODE_RESTART, 1'b0});
		p.drive_level(1'b1);
		wait_irq(cirq, 1000);
		check("restart capture", 32'h0000_0001, {31'h0, hit});
		apb(1'b0, OFS_COUNT, 32'h0);
		check("restart cleared", 32'h0000_0001, {31'h0, (rd < 32'd20)});
		p.drive_level(1'b0);
		wait_irq(cirq, 600);
		check("fall ignored", 32'h0000_0000, {31'h0, hit});
	endtask : t_capture
	task automatic t_halt;
		apb(1'b1, OFS_MODE_CONTROL, 32'h0);
		apb(1'b1, OFS_EDGE_MODE, 32'h0000_000C);
		apb(1'b1, OFS_SAMPLE_SELECT, {30'h0, SCS_CPU});
		apb(1'b1, OFS_MODE_CONTROL, {28'h0, TPC_MODE_FREE, 1'b0});
		halt <= 1'b1;
		p.drive_level(1'b1);
		wait_irq(cirq, 300);
		check("halt stops cpu sampling", 32'h0000_0000, {31'h0, hit});
		@(posedge clock_i);
		halt <= 1'b0;
		wait_irq(cirq, 300);
		check("cpu sampling resumes", 32'h0000_0001, {31'h0, hit});
		apb(1'b1, OFS_SAMPLE_SELECT, {30'h0, SCS_DIV64});
		halt <= 1'b1;
		p.drive_level(1'b0);
		wait_irq(cirq, 1000);
		check("fixed sampling in halt", 32'h0000_0001, {31'h0, hit});
		@(posedge clock_i);
		halt <= 1'b0;
	endtask : t_halt
	task automatic t_ext;
		logic [2:0] seen;
		apb(1'b1, OFS_MODE_CONTROL, 32'h0);
		apb(1'b1, OFS_EDGE_MODE, 32'h0000_00DC);
		seen = 3'b000;
		ext <= 3'b000;
		repeat (12) begin
			@(negedge clock_i);
			seen = seen | eirq;
		end
		check("ext falling irqs", 32'h0000_0006, {29'h0, seen});
		@(posedge clock_i);
		seen = 3'b000;
		ext <= 3'b111;
		repeat (12) begin
			@(negedge clock_i);
			seen = seen | eirq;
		end
		check("ext rising irqs", 32'h0000_0003, {29'h0, seen});
	endtask : t_ext
	initial begin
		nrst_i = 1'b0;
		{psel, penable, pwrite, clr} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		ext = 3'b111;
		halt = 1'b0;
		repeat (10) @(posedge clock_i);
		nrst_i <= 1'b1;
		t_reset_regs();
		t_interval();
		apb(1'b1, OFS_PORT_DIR, 32'h0000_00FE);
		apb(1'b1, OFS_PORT_LATCH, 32'h0);
		t_pwm(32'h0000_0001, 128);
		t_pwm(32'h0000_0003, 384);
		t_capture();
		t_halt();
		t_ext();
		finish_test();
	end
endmodule : tpc_timer_tb
